// ---- hdl/asfr_status_reg.sv ----
// status register: alu flags, reset-cause flags and bank select bits
// assumes the core gives one-cycle instruction strobes on i_sys_clk and
// that reset-cause pulses come from logic already on this clock
`timescale 1ns/100ps
`include "asfr_params.svh"
module asfr_status_reg (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_wr_en,
  input  wire logic [6:0]             i_file_addr,
  input  wire logic [7:0]             i_wr_data,
  input  wire asfr_pkg::asfr_alu_op_t i_alu_op,
  input  wire logic [7:0]             i_op_a,
  input  wire logic [7:0]             i_op_b,
  input  wire logic [7:0]             i_logic_res,
  input  wire logic                   i_sleep_op,
  input  wire logic                   i_clrwdt_op,
  input  wire logic                   i_wdt_timeout,
  input  wire logic                   i_master_clear_reset_rst,
  input  wire logic                   i_bor_rst,
  input  wire logic                   i_wdt_rst,
  output logic [7:0]                  o_status,
  output logic [7:0]                  o_rd_data,
  output logic [7:0]                  o_alu_result,
  output logic [7:0]                  o_bank_addr
);
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic       hit;
  logic       upd_z;
  logic       upd_dcc;
  logic       any_rst;

  asfr_alu_if alu ();

  assign alu.op        = i_alu_op;
  assign alu.op_a      = i_op_a;
  assign alu.op_b      = i_op_b;
  assign alu.logic_res = i_logic_res;

  asfr_flag_gen u_flag_gen (
    .alu (alu.gen)
  );

  // both bank images of the register decode to the same storage
  assign hit     = i_wr_en && (i_file_addr == `ASFR_STATUS_OFFSET);
  assign upd_dcc = (i_alu_op == asfr_pkg::ASFR_OP_ADD) ||
                   (i_alu_op == asfr_pkg::ASFR_OP_SUB);
  assign upd_z   = upd_dcc || (i_alu_op == asfr_pkg::ASFR_OP_LOGIC) ||
                   (i_alu_op == asfr_pkg::ASFR_OP_CLR);
  assign any_rst = i_master_clear_reset_rst || i_bor_rst || i_wdt_rst;

  always_comb begin
    nxt_status = status_ff;
    if (hit) begin
      nxt_status[`ASFR_UPPER_MSB:`ASFR_UPPER_LSB] =
        i_wr_data[`ASFR_UPPER_MSB:`ASFR_UPPER_LSB];
      // expiry and sleep bits are never taken from write data
      if (!upd_z) begin
        nxt_status[`ASFR_FLAGS_MSB:0] = i_wr_data[`ASFR_FLAGS_MSB:0];
      end
    end
    if (upd_z) begin
      nxt_status[`ASFR_BIT_NULL] = alu.z;
    end
    if (upd_dcc) begin
      nxt_status[`ASFR_BIT_NIBBLE] = alu.dc;
      nxt_status[`ASFR_BIT_BORROW] = alu.c;
    end
    if (i_sleep_op) begin
      nxt_status[`ASFR_BIT_WDT_EXPIRY] = 1'b1;
      nxt_status[`ASFR_BIT_SLEEP]      = 1'b0;
    end
    if (i_clrwdt_op) begin
      nxt_status[`ASFR_BIT_WDT_EXPIRY] = 1'b1;
      nxt_status[`ASFR_BIT_SLEEP]      = 1'b1;
    end
    // a timeout landing with sleep or clear-watchdog still wins
    if (i_wdt_timeout) begin
      nxt_status[`ASFR_BIT_WDT_EXPIRY] = 1'b0;
    end
    if (any_rst) begin
      nxt_status[`ASFR_UPPER_MSB:`ASFR_UPPER_LSB] = 3'h0;
      // the aborted instruction leaves its arithmetic flags unchanged
      nxt_status[`ASFR_FLAGS_MSB:0] = status_ff[`ASFR_FLAGS_MSB:0];
      if (i_bor_rst) begin
        nxt_status[`ASFR_BIT_WDT_EXPIRY] = 1'b1;
        nxt_status[`ASFR_BIT_SLEEP]      = 1'b1;
      end
      if (i_wdt_rst) begin
        nxt_status[`ASFR_BIT_WDT_EXPIRY] = 1'b0;
      end
    end
    nxt_rd_data = nxt_status & `ASFR_READ_MASK;
    nxt_result  = alu.result;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_ff  <= `ASFR_POR_VALUE;
      rd_data_ff <= `ASFR_POR_VALUE;
      result_ff  <= 8'h00;
    end else begin
      status_ff  <= nxt_status;
      rd_data_ff <= nxt_rd_data;
      result_ff  <= nxt_result;
    end
  end

  assign o_status     = status_ff;
  assign o_rd_data    = rd_data_ff;
  assign o_alu_result = result_ff;
  // direct address: bank select low forms the top address bit
  assign o_bank_addr  = {status_ff[`ASFR_BIT_BANK_LOW], i_file_addr};

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_wr_upper;
    hit && !any_rst |=> status_ff[7:5] == $past(i_wr_data[7:5]);
  endproperty
  a_wr_upper: assert property (p_wr_upper)
    else $error("status upper bits not written");

  property p_flag_suppress;
    hit && upd_dcc && !any_rst |=>
      status_ff[1:0] == $past({alu.dc, alu.c});
  endproperty
  a_flag_suppress: assert property (p_flag_suppress)
    else $error("write data reached arithmetic flags");

  property p_z_suppress;
    hit && upd_z && !any_rst |=> status_ff[2] == $past(alu.z);
  endproperty
  a_z_suppress: assert property (p_z_suppress)
    else $error("write data reached zero flag");

  property p_ro_flags;
    hit && !i_sleep_op && !i_clrwdt_op && !i_wdt_timeout && !any_rst
      |=> $stable(status_ff[4:3]);
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("reset-cause flags changed by write");

  property p_clear;
    hit && (i_alu_op == asfr_pkg::ASFR_OP_CLR) && (i_wr_data == 8'h00) &&
      !any_rst && !i_sleep_op && !i_clrwdt_op && !i_wdt_timeout
      |=> status_ff[7:5] == 3'h0 && status_ff[2] &&
          status_ff[4:3] == $past(status_ff[4:3]) &&
          status_ff[1:0] == $past(status_ff[1:0]);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear of status gave wrong value");

  property p_bank;
    o_bank_addr[7] == status_ff[5] && o_bank_addr[6:0] == i_file_addr;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank address mismatch");

  property p_borrow;
    (i_alu_op == asfr_pkg::ASFR_OP_SUB) && !hit && !any_rst &&
      (i_op_a < i_op_b) |=> !status_ff[0] && !o_rd_data[0];
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("borrow not shown as cleared carry");

  property p_digit_borrow;
    (i_alu_op == asfr_pkg::ASFR_OP_SUB) && !hit && !any_rst &&
      (i_op_a[3:0] < i_op_b[3:0]) |=> !status_ff[1];
  endproperty
  a_digit_borrow: assert property (p_digit_borrow)
    else $error("digit borrow not shown as cleared nibble carry");

  property p_carry_out;
    (i_alu_op == asfr_pkg::ASFR_OP_ADD) && !any_rst &&
      (({1'b0, i_op_a} + {1'b0, i_op_b}) > 9'h0FF) |=> status_ff[0];
  endproperty
  a_carry_out: assert property (p_carry_out)
    else $error("carry out of bit seven not captured");

  property p_rd_mask;
    o_rd_data == (o_status & `ASFR_READ_MASK);
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("read data does not match register");

  property p_nonpor;
    any_rst |=> status_ff[7:5] == 3'h0 &&
                status_ff[2:0] == $past(status_ff[2:0]);
  endproperty
  a_nonpor: assert property (p_nonpor)
    else $error("non-power-up reset value wrong");

  property p_sleep;
    i_sleep_op && !i_clrwdt_op && !i_wdt_timeout && !any_rst
      |=> status_ff[4] && !status_ff[3] && o_rd_data[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flags wrong");

  property p_zero;
    upd_z && !any_rst |=> status_ff[2] == ($past(alu.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  c_clear: cover property (hit && i_alu_op == asfr_pkg::ASFR_OP_CLR);
  c_sleep: cover property (i_sleep_op && i_wdt_timeout);
  c_wdt_rst: cover property (i_wdt_rst);
  c_borrow: cover property (i_alu_op == asfr_pkg::ASFR_OP_SUB &&
                            i_op_a < i_op_b);
endmodule // asfr_status_reg

// ---- hdl/asfr_params.svh ----
// constants for the arithmetic, reset-cause and bank status register
// assumes it is included by name wherever an offset or bit number is needed
`ifndef ASFR_PARAMS_SVH
`define ASFR_PARAMS_SVH

`define ASFR_STATUS_OFFSET   7'h03
`define ASFR_BIT_INDIRECT    7
`define ASFR_BIT_BANK_HIGH   6
`define ASFR_BIT_BANK_LOW    5
`define ASFR_BIT_WDT_EXPIRY  4
`define ASFR_BIT_SLEEP       3
`define ASFR_BIT_NULL        2
`define ASFR_BIT_NIBBLE      1
`define ASFR_BIT_BORROW      0
`define ASFR_POR_VALUE       8'h18
`define ASFR_READ_MASK       8'hFF
`define ASFR_UPPER_MSB       7
`define ASFR_UPPER_LSB       5
`define ASFR_FLAGS_MSB       2

`endif

// ---- hdl/asfr_pkg.sv ----
// types shared by the status register and its flag generator
package asfr_pkg;
  typedef enum logic [2:0] {
    ASFR_OP_NONE,
    ASFR_OP_ADD,
    ASFR_OP_SUB,
    ASFR_OP_LOGIC,
    ASFR_OP_CLR
  } asfr_alu_op_t;
endpackage

// ---- hdl/asfr_alu_if.sv ----
// operand and flag bundle between the status register and flag generator
// assumes both ends run on the same instruction clock
`timescale 1ns/100ps
interface asfr_alu_if;
  asfr_pkg::asfr_alu_op_t op;
  logic [7:0]             op_a;
  logic [7:0]             op_b;
  logic [7:0]             logic_res;
  logic [7:0]             result;
  logic                   z;
  logic                   dc;
  logic                   c;
  modport core (output op, op_a, op_b, logic_res,
                input  result, z, dc, c);
  modport gen  (input  op, op_a, op_b, logic_res,
                output result, z, dc, c);
endinterface

// ---- hdl/asfr_flag_gen.sv ----
// alu flag generator: zero, nibble carry and carry/borrow of one operation
// assumes operands are stable for the cycle in which the op is presented
`timescale 1ns/100ps
module asfr_flag_gen (
  asfr_alu_if.gen alu
);
  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    sum9       = 9'h000;
    nib5       = 5'h00;
    alu.result = 8'h00;
    case (alu.op)
      asfr_pkg::ASFR_OP_ADD: begin
        sum9 = {1'b0, alu.op_a} + {1'b0, alu.op_b};
        nib5 = {1'b0, alu.op_a[3:0]} + {1'b0, alu.op_b[3:0]};
        alu.result = sum9[7:0];
      end
      asfr_pkg::ASFR_OP_SUB: begin
        // two's complement add: carry out high means no borrow
        sum9 = {1'b0, alu.op_a} + {1'b0, ~alu.op_b} + 9'h001;
        nib5 = {1'b0, alu.op_a[3:0]} + {1'b0, ~alu.op_b[3:0]} + 5'h01;
        alu.result = sum9[7:0];
      end
      asfr_pkg::ASFR_OP_LOGIC: begin
        alu.result = alu.logic_res;
      end
      default: begin
        alu.result = 8'h00;
      end
    endcase
    alu.z  = (alu.result == 8'h00);
    alu.dc = nib5[4];
    alu.c  = sum9[8];
  end
endmodule // asfr_flag_gen

// ---- verif/asfr_core_model.sv ----
// core-side model: instruction write data and logic-unit result
// assumes the bench changes its inputs on the falling clock edge
`timescale 1ns/100ps
module asfr_core_model (
  input  wire logic [7:0] i_data,
  input  wire logic [7:0] i_op_a,
  input  wire logic [7:0] i_op_b,
  output logic [7:0]      o_wr_data,
  output logic [7:0]      o_logic_res
);
  // software never uses the two unused bank bits as storage
  assign o_wr_data   = {2'b00, i_data[5:0]};
  assign o_logic_res = i_op_a & i_op_b;
endmodule // asfr_core_model

// ---- verif/alu_status_flag_register_test.sv ----
// self-checking bench for the status register
// assumes the core model shapes write data; events are one-cycle pulses
`timescale 1ns/100ps
module alu_status_flag_register_test;
  logic                   i_sys_clk = 1'b0;
  logic                   i_reset_n = 1'b0;
  logic                   we        = 1'b0;
  logic [6:0]             addr      = 7'h03;
  logic [7:0]             data      = 8'h00;
  logic [7:0]             a         = 8'h00;
  logic [7:0]             b         = 8'h00;
  logic [5:0]             ev        = 6'h00;
  asfr_pkg::asfr_alu_op_t op        = asfr_pkg::ASFR_OP_NONE;
  logic [7:0]             wd, lr, st, rd, ar, ba;
  int                     num_errors = 0;
  int                     cmp_count  = 0;

  localparam asfr_pkg::asfr_alu_op_t op_none = asfr_pkg::ASFR_OP_NONE;
  localparam asfr_pkg::asfr_alu_op_t op_add  = asfr_pkg::ASFR_OP_ADD;
  localparam asfr_pkg::asfr_alu_op_t op_sub  = asfr_pkg::ASFR_OP_SUB;
  localparam asfr_pkg::asfr_alu_op_t op_log  = asfr_pkg::ASFR_OP_LOGIC;
  localparam asfr_pkg::asfr_alu_op_t op_clr  = asfr_pkg::ASFR_OP_CLR;

  asfr_core_model u_asfr_core_model (.i_data(data), .i_op_a(a),
    .i_op_b(b), .o_wr_data(wd), .o_logic_res(lr));
  asfr_status_reg u_asfr_status_reg (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_wr_en(we), .i_file_addr(addr),
    .i_wr_data(wd), .i_alu_op(op), .i_op_a(a), .i_op_b(b),
    .i_logic_res(lr), .i_sleep_op(ev[5]), .i_clrwdt_op(ev[4]),
    .i_wdt_timeout(ev[3]), .i_master_clear_reset_rst(ev[2]), .i_bor_rst(ev[1]),
    .i_wdt_rst(ev[0]), .o_status(st), .o_rd_data(rd),
    .o_alu_result(ar), .o_bank_addr(ba));

  always #10 i_sys_clk = ~i_sys_clk;

  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  // one instruction cycle, then idle; checks status after it lands
  task automatic go(asfr_pkg::asfr_alu_op_t o, logic [7:0] x,
                    logic [7:0] y, logic w, logic [7:0] d,
                    logic [5:0] e, logic [7:0] exp);
    @(negedge i_sys_clk);
    op = o; a = x; b = y; we = w; data = d; ev = e;
    addr = w ? 7'h03 : 7'h10;
    @(negedge i_sys_clk);
    op = asfr_pkg::ASFR_OP_NONE; we = 1'b0; ev = 6'h00; addr = 7'h03;
    chk("status", st, exp);
    chk("read", rd, exp);
  endtask

  task automatic t_reset;
    chk("por", st, 8'h18);
    chk("por read", rd, 8'h18);
    chk("por result", ar, 8'h00);
  endtask

  // power-up reset again in mid-run, then one write to prove it recovers
  task automatic t_power_up;
    @(negedge i_sys_clk);
    i_reset_n = 1'b0;
    @(negedge i_sys_clk);
    t_reset;
    i_reset_n = 1'b1;
    go(op_none, 8'h00, 8'h00, 1'b1, 8'h20, 6'h00, 8'h38);
  endtask

  task automatic t_write_clear;
    go(op_none, 8'h00, 8'h00, 1'b1, 8'hFF, 6'h00, 8'h3F);
    chk("bank1", ba, 8'h83);
    go(op_clr, 8'h00, 8'h00, 1'b1, 8'h00, 6'h00, 8'h1F);
    chk("bank0", ba, 8'h03);
  endtask

  task automatic t_arith;
    go(op_sub, 8'h10, 8'h01, 1'b1, 8'h07, 6'h00, 8'h19);
    chk("result", ar, 8'h0F);
    go(op_add, 8'hF8, 8'h08, 1'b0, 8'h00, 6'h00, 8'h1F);
    chk("result", ar, 8'h00);
    go(op_add, 8'h08, 8'h08, 1'b0, 8'h00, 6'h00, 8'h1A);
    chk("result", ar, 8'h10);
    go(op_log, 8'hF0, 8'h0F, 1'b0, 8'h00, 6'h00, 8'h1E);
    chk("result", ar, 8'h00);
    go(op_sub, 8'h05, 8'h07, 1'b0, 8'h00, 6'h00, 8'h18);
    chk("result", ar, 8'hFE);
  endtask

  task automatic t_events;
    go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, 6'h20, 8'h10);
    go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, 6'h10, 8'h18);
    go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, 6'h28, 8'h00);
    go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, 6'h10, 8'h18);
    go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, 6'h08, 8'h08);
  endtask

  task automatic t_resets;
    logic [5:0] rs [3] = '{6'h04, 6'h02, 6'h01};
    logic [7:0] ew [3] = '{8'h28, 8'h28, 8'h38};
    logic [7:0] er [3] = '{8'h08, 8'h18, 8'h08};
    for (int i = 0; i < 3; i++) begin
      go(op_none, 8'h00, 8'h00, 1'b1, 8'h20, 6'h00, ew[i]);
      go(op_none, 8'h00, 8'h00, 1'b0, 8'h00, rs[i], er[i]);
    end
  endtask

  task automatic results;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(100_000);
    num_errors++;
    results;
  end

  initial begin
    repeat (4) @(negedge i_sys_clk);
    t_reset;
    i_reset_n = 1'b1;
    t_write_clear;
    t_arith;
    t_events;
    t_resets;
    t_power_up;
    results;
  end
endmodule // alu_status_flag_register_test
